// ===== rtl/fbm_defs.svh
`ifndef FBM_DEFS_SVH
`define FBM_DEFS_SVH

// Register offsets on the plain register port
`define FBM_OFF_FLASH_CONTROL_ONE 8'h00
`define FBM_OFF_FLASH_CONTROL_TWO 8'h01
`define FBM_OFF_ERASE_BLOCK_SELECT 8'h02
`define FBM_OFF_FLASH_POWER_CONTROL 8'h03
`define FBM_OFF_FLASH_CONTROL_ACCESS_ENABLE 8'h04
`define FBM_OFF_BOOT_STATUS 8'h05
`define FBM_OFF_BIT_RATE_LO 8'h06
`define FBM_OFF_BIT_RATE_HI 8'h07
`define FBM_OFF_SERIAL_CONTROL 8'h08

// Field positions
`define FBM_BIT_POWERDOWN_INHIBIT 7
`define FBM_BIT_CTRL_REG_ACCESS_GATE 7
`define FBM_BIT_SOFTWARE_WRITE_ENABLE 6
`define FBM_BIT_FLASH_ERROR 7
`define FBM_BIT_SERIAL_RECEIVE_ENABLE 0
`define FBM_BIT_SERIAL_TRANSMIT_ENABLE 1

// Reset values
`define FBM_RST_REG8 8'h00
`define FBM_RST_EBR 5'h00

// Boot protocol constants
`define FBM_BYTE_RATE_DONE 8'h00
`define FBM_BYTE_HOST_REPLY 8'h55
`define FBM_RAM_START 16'hf780
`define FBM_RAM_END 16'hfeef
`define FBM_LOW_PERIOD_BITS 4'd9

// Timing counts, in system clock states
`define FBM_MEAS_READY_STATES 100
`define FBM_MIN_DIVISOR 16'd4

`endif

// ===== rtl/fbm_pkg.sv
package fbm_pkg;

  // Operating mode caught at reset release
  typedef enum logic [3:0] {
    FBM_MODE_NONE = 4'b0001,
    FBM_MODE_USER = 4'b0010,
    FBM_MODE_BOOT = 4'b0100,
    FBM_MODE_PROG = 4'b1000
  } fbm_mode_t;

  // Boot loader sequence
  typedef enum logic [12:0] {
    FBM_ST_IDLE      = 13'b0000000000001,
    FBM_ST_SETTLE    = 13'b0000000000010,
    FBM_ST_WAIT_HIGH = 13'b0000000000100,
    FBM_ST_ARM       = 13'b0000000001000,
    FBM_ST_MEASURE   = 13'b0000000010000,
    FBM_ST_SEND_ACK  = 13'b0000000100000,
    FBM_ST_ACK_WAIT  = 13'b0000001000000,
    FBM_ST_WAIT_55   = 13'b0000010000000,
    FBM_ST_LEN_HI    = 13'b0000100000000,
    FBM_ST_LEN_LO    = 13'b0001000000000,
    FBM_ST_LOAD      = 13'b0010000000000,
    FBM_ST_ERASE     = 13'b0100000000000,
    FBM_ST_RUN       = 13'b1000000000000
  } fbm_state_t;

endpackage : fbm_pkg

// ===== rtl/fbm_serial.sv
`timescale 1ns/1ps
// Asynchronous serial port, 8 data bits, 1 stop bit, no parity, LSB first
module fbm_serial #(
  parameter int DIV_W = 16
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // Control
  input wire logic [DIV_W-1:0] i_div,
  input wire logic i_rx_en,
  input wire logic i_tx_en,
  // Receive side
  input wire logic i_rxd,
  output logic o_rx_valid,
  output logic [7:0] o_rx_data,
  output logic o_rx_err,
  // Transmit side
  input wire logic i_tx_start,
  input wire logic [7:0] i_tx_data,
  output logic o_tx_busy,
  output logic o_txd
);

  generate
    if (DIV_W < 4) begin : g_bad_width
      $error("fbm_serial: DIV_W must be at least 4");
    end
  endgenerate

  logic rx_busy_q;
  logic [DIV_W-1:0] rx_cnt_q;
  logic [3:0] rx_bit_q;
  logic [7:0] rx_sh_q;
  logic [DIV_W-1:0] tx_cnt_q;
  logic [3:0] tx_bit_q;
  logic [8:0] tx_sh_q;

  //////////////////////////////////////////////////////////////////////////////
  // Receiver: samples each bit in its middle; a start bit that is gone at
  // mid-bit is taken as a glitch and dropped
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rx_busy_q <= 1'b0;
      rx_cnt_q <= '0;
      rx_bit_q <= 4'h0;
      rx_sh_q <= 8'h00;
      o_rx_valid <= 1'b0;
      o_rx_data <= 8'h00;
      o_rx_err <= 1'b0;
    end else begin
      o_rx_valid <= 1'b0;
      o_rx_err <= 1'b0;
      if (!i_rx_en) begin
        rx_busy_q <= 1'b0;
      end else if (!rx_busy_q) begin
        if (!i_rxd) begin
          rx_busy_q <= 1'b1;
          rx_cnt_q <= i_div >> 1;
          rx_bit_q <= 4'h0;
        end
      end else if (rx_cnt_q != '0) begin
        rx_cnt_q <= rx_cnt_q - 1'b1;
      end else begin
        rx_cnt_q <= i_div - 1'b1;
        if (rx_bit_q == 4'h0) begin
          if (i_rxd) begin
            rx_busy_q <= 1'b0;
          end
          rx_bit_q <= 4'h1;
        end else if (rx_bit_q <= 4'h8) begin
          rx_sh_q <= {i_rxd, rx_sh_q[7:1]};
          rx_bit_q <= rx_bit_q + 4'h1;
        end else begin
          // Stop bit: a low here is a framing error
          rx_busy_q <= 1'b0;
          o_rx_valid <= i_rxd;
          o_rx_err <= ~i_rxd;
          if (i_rxd) begin
            o_rx_data <= rx_sh_q;
          end
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Transmitter: line idles high, also while disabled
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_tx_busy <= 1'b0;
      o_txd <= 1'b1;
      tx_cnt_q <= '0;
      tx_bit_q <= 4'h0;
      tx_sh_q <= 9'h1ff;
    end else if (!i_tx_en) begin
      o_tx_busy <= 1'b0;
      o_txd <= 1'b1;
    end else if (!o_tx_busy) begin
      o_txd <= 1'b1;
      if (i_tx_start) begin
        o_tx_busy <= 1'b1;
        o_txd <= 1'b0;
        tx_sh_q <= {1'b1, i_tx_data};
        tx_cnt_q <= i_div - 1'b1;
        tx_bit_q <= 4'h0;
      end
    end else if (tx_cnt_q != '0) begin
      tx_cnt_q <= tx_cnt_q - 1'b1;
    end else if (tx_bit_q == 4'h9) begin
      o_tx_busy <= 1'b0;
    end else begin
      o_txd <= tx_sh_q[0];
      tx_sh_q <= {1'b1, tx_sh_q[8:1]};
      tx_bit_q <= tx_bit_q + 4'h1;
      tx_cnt_q <= i_div - 1'b1;
    end
  end

endmodule : fbm_serial

// ===== rtl/fbm_flash_boot_ctrl.sv
//
// Operation
// - Power-down inhibit 0 plus subactive sends flash to power-down; 1 keeps it readable.
// - Bits 6..0 of power control and access enable reset to and read zero.
// - Flash control registers are reachable only while the access gate is 1.
// - Mode from pins at reset end: user, boot or programmer.
// - Boot: load program into RAM, erase whole flash, run the program.
// - Boot link framing is 8 data bits, 1 stop bit, no parity.
// - Time the low period of host zero bytes and match its bit rate.
// - About 100 states after reset before low-period timing begins.
// - After matching, send one zero byte to signal completion.
// - Program lands in RAM 0xf780 to 0xfeef.
// - Before branching clear receive and transmit enables, keep bit rate.
// - Watchdog overflow also leaves boot mode.
// - User program mode allows block erase and program by software.
//
`timescale 1ns/1ps
`include "fbm_defs.svh"

module fbm_flash_boot_ctrl #(
  parameter int DIV_W = 16,
  parameter int MEAS_READY_STATES = `FBM_MEAS_READY_STATES
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // Register port
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // Mode pins, held by the board around reset release
  input wire logic i_test,
  input wire logic i_nmi,
  input wire logic i_port8_pin5,
  input wire logic i_portb_pin0,
  input wire logic i_portb_pin1,
  input wire logic i_portb_pin2,
  output fbm_pkg::fbm_mode_t o_mode,
  // Chip state and flash array
  input wire logic i_subactive,
  input wire logic i_watchdog_overflow,
  input wire logic i_flash_error,
  input wire logic i_flash_erase_done,
  output logic o_flash_powerdown,
  output logic o_flash_erase_all,
  output logic [7:0] o_flash_control_one,
  output logic [4:0] o_erase_block_select,
  // Boot serial pins
  input wire logic i_rxd,
  output logic o_txd,
  output logic o_txd_oe,
  // On-chip RAM write port and branch
  output logic o_ram_we,
  output logic [15:0] o_ram_addr,
  output logic [7:0] o_ram_wdata,
  output logic o_run_program
);

  import fbm_pkg::*;

  generate
    if (DIV_W < 8 || MEAS_READY_STATES < 1 || MEAS_READY_STATES > 255) begin : g_bad_param
      $error("fbm_flash_boot_ctrl: unsupported parameter value");
    end
  endgenerate

  localparam logic [7:0] READY_CNT = 8'(MEAS_READY_STATES - 1);
  localparam logic [15:0] RAM_BYTES = `FBM_RAM_END - `FBM_RAM_START + 16'h0001;

  fbm_state_t state_q;
  logic cap_done_q;
  logic [6:0] fc1_q;
  logic [4:0] ebr_q;
  logic powerdown_inhibit_q;
  logic gate_q;
  logic rx_en_q;
  logic tx_en_q;
  logic load_fail_q;
  logic [DIV_W-1:0] div_q;
  logic [DIV_W-1:0] meas_q;
  logic [3:0] sub_q;
  logic [7:0] wait_q;
  logic [15:0] len_q;
  logic rx_valid;
  logic rx_err;
  logic [7:0] rx_data;
  logic tx_busy;
  logic tx_start;
  logic wr_ok;
  logic rd_ok;
  logic gated_addr;

  //////////////////////////////////////////////////////////////////////////////
  // Register access decode
  assign gated_addr = (i_addr == `FBM_OFF_FLASH_CONTROL_ONE) || (i_addr == `FBM_OFF_FLASH_CONTROL_TWO) ||
                      (i_addr == `FBM_OFF_ERASE_BLOCK_SELECT) || (i_addr == `FBM_OFF_FLASH_POWER_CONTROL);
  assign wr_ok = i_wr && (!gated_addr || gate_q);
  assign rd_ok = i_rd && (!gated_addr || gate_q);
  // Completion byte request
  // The request also opens the transmitter, since the enable flop only lands one edge later
  assign tx_start = (state_q == FBM_ST_SEND_ACK);

  //////////////////////////////////////////////////////////////////////////////
  // Mode straps, caught by the first clock after reset release so the flop
  // never loads a pin under the asynchronous reset
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cap_done_q <= 1'b0;
      o_mode <= FBM_MODE_NONE;
    end else if (!cap_done_q) begin
      cap_done_q <= 1'b1;
      if (!i_test && i_nmi) begin
        o_mode <= FBM_MODE_USER;
      end else if (!i_test && i_port8_pin5) begin
        o_mode <= FBM_MODE_BOOT;
      end else if (i_test && !i_portb_pin0 && !i_portb_pin1 && !i_portb_pin2) begin
        o_mode <= FBM_MODE_PROG;
      end else begin
        o_mode <= FBM_MODE_NONE;
      end
    end else if (i_watchdog_overflow && o_mode == FBM_MODE_BOOT) begin
      o_mode <= FBM_MODE_USER;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Flash control one and erase block select; erase block clears whenever
  // software write enable is off or more than one block is asked for
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      fc1_q <= 7'h00;
      ebr_q <= `FBM_RST_EBR;
    end else begin
      if (wr_ok && i_addr == `FBM_OFF_FLASH_CONTROL_ONE) begin
        fc1_q <= i_wdata[6:0];
      end
      if (!fc1_q[`FBM_BIT_SOFTWARE_WRITE_ENABLE]) begin
        ebr_q <= `FBM_RST_EBR;
      end else if (wr_ok && i_addr == `FBM_OFF_ERASE_BLOCK_SELECT) begin
        ebr_q <= ($countones(i_wdata[4:0]) > 1) ? `FBM_RST_EBR : i_wdata[4:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Power control and access gate; only bit 7 of each is stored
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      powerdown_inhibit_q <= 1'b0;
      gate_q <= 1'b0;
    end else begin
      if (wr_ok && i_addr == `FBM_OFF_FLASH_POWER_CONTROL) begin
        powerdown_inhibit_q <= i_wdata[`FBM_BIT_POWERDOWN_INHIBIT];
      end
      if (wr_ok && i_addr == `FBM_OFF_FLASH_CONTROL_ACCESS_ENABLE) begin
        gate_q <= i_wdata[`FBM_BIT_CTRL_REG_ACCESS_GATE];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the strobe; unmapped or gated reads give zero
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rdata <= `FBM_RST_REG8;
    end else if (!rd_ok) begin
      o_rdata <= 8'h00;
    end else begin
      unique case (i_addr)
        `FBM_OFF_FLASH_CONTROL_ONE: o_rdata <= {1'b0, fc1_q};
        `FBM_OFF_FLASH_CONTROL_TWO: o_rdata <= {i_flash_error, 7'h00};
        `FBM_OFF_ERASE_BLOCK_SELECT: o_rdata <= {3'h0, ebr_q};
        `FBM_OFF_FLASH_POWER_CONTROL: o_rdata <= {powerdown_inhibit_q, 7'h00};
        `FBM_OFF_FLASH_CONTROL_ACCESS_ENABLE: o_rdata <= {gate_q, 7'h00};
        `FBM_OFF_BOOT_STATUS: o_rdata <= {1'b0, load_fail_q, o_run_program, o_flash_erase_all, o_mode};
        `FBM_OFF_BIT_RATE_LO: o_rdata <= div_q[7:0];
        `FBM_OFF_BIT_RATE_HI: o_rdata <= 8'(div_q >> 8);
        `FBM_OFF_SERIAL_CONTROL: o_rdata <= {6'h00, tx_en_q, rx_en_q};
        default: o_rdata <= 8'h00;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Flash power-down follows subactive unless inhibited
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_flash_powerdown <= 1'b0;
    end else begin
      o_flash_powerdown <= i_subactive && !powerdown_inhibit_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Boot loader sequence
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_q <= FBM_ST_IDLE;
      wait_q <= 8'h00;
      sub_q <= 4'h0;
      meas_q <= '0;
      div_q <= '1;
      len_q <= 16'h0000;
      load_fail_q <= 1'b0;
    end else if (i_watchdog_overflow && o_mode == FBM_MODE_BOOT) begin
      state_q <= FBM_ST_IDLE;
    end else begin
      unique case (state_q)
        FBM_ST_IDLE: begin
          if (cap_done_q && o_mode == FBM_MODE_BOOT && !o_run_program) begin
            state_q <= FBM_ST_SETTLE;
            wait_q <= 8'h00;
          end
        end
        FBM_ST_SETTLE: begin
          if (wait_q == READY_CNT) begin
            state_q <= FBM_ST_WAIT_HIGH;
          end else begin
            wait_q <= wait_q + 8'h01;
          end
        end
        FBM_ST_WAIT_HIGH: begin
          if (i_rxd) begin
            state_q <= FBM_ST_ARM;
          end
        end
        FBM_ST_ARM: begin
          if (!i_rxd) begin
            state_q <= FBM_ST_MEASURE;
            sub_q <= 4'h1;
            meas_q <= '0;
          end
        end
        FBM_ST_MEASURE: begin
          if (!i_rxd) begin
            // Nine bit times per low period
            if (sub_q == `FBM_LOW_PERIOD_BITS - 4'd1) begin
              sub_q <= 4'h0;
              if (meas_q == '1) begin
                state_q <= FBM_ST_WAIT_HIGH;
              end else begin
                meas_q <= meas_q + 1'b1;
              end
            end else begin
              sub_q <= sub_q + 4'h1;
            end
          end else if (meas_q >= DIV_W'(`FBM_MIN_DIVISOR)) begin
            div_q <= meas_q;
            state_q <= FBM_ST_SEND_ACK;
          end else begin
            state_q <= FBM_ST_WAIT_HIGH;
          end
        end
        FBM_ST_SEND_ACK: begin
          state_q <= FBM_ST_ACK_WAIT;
        end
        FBM_ST_ACK_WAIT: begin
          if (!tx_busy) begin
            state_q <= FBM_ST_WAIT_55;
          end
        end
        FBM_ST_WAIT_55: begin
          // Stray zero bytes still in flight from the host are skipped
          if (rx_valid && rx_data == `FBM_BYTE_HOST_REPLY) begin
            state_q <= FBM_ST_LEN_HI;
          end
        end
        FBM_ST_LEN_HI: begin
          if (rx_valid) begin
            len_q[15:8] <= rx_data;
            state_q <= FBM_ST_LEN_LO;
          end
        end
        FBM_ST_LEN_LO: begin
          if (rx_valid) begin
            // Length must fit the RAM window
            if ({len_q[15:8], rx_data} == 16'h0000 || {len_q[15:8], rx_data} > RAM_BYTES) begin
              load_fail_q <= 1'b1;
              state_q <= FBM_ST_IDLE;
            end else begin
              len_q <= {len_q[15:8], rx_data};
              state_q <= FBM_ST_LOAD;
            end
          end
        end
        FBM_ST_LOAD: begin
          if (rx_valid) begin
            len_q <= len_q - 16'h0001;
            if (len_q == 16'h0001) begin
              state_q <= FBM_ST_ERASE;
            end
          end
        end
        FBM_ST_ERASE: begin
          if (i_flash_erase_done) begin
            state_q <= FBM_ST_RUN;
          end
        end
        FBM_ST_RUN: begin
          state_q <= FBM_ST_IDLE;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // RAM write port for the received program
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_ram_we <= 1'b0;
      o_ram_addr <= `FBM_RAM_START;
      o_ram_wdata <= 8'h00;
    end else begin
      o_ram_we <= 1'b0;
      if (state_q == FBM_ST_LEN_LO) begin
        o_ram_addr <= `FBM_RAM_START;
      end else if (o_ram_we) begin
        o_ram_addr <= o_ram_addr + 16'h0001;
      end
      if (state_q == FBM_ST_LOAD && rx_valid) begin
        o_ram_we <= 1'b1;
        o_ram_wdata <= rx_data;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Whole-array erase request and branch to the loaded program
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_flash_erase_all <= 1'b0;
      o_run_program <= 1'b0;
    end else begin
      o_flash_erase_all <= (state_q == FBM_ST_LOAD && rx_valid && len_q == 16'h0001) ||
                           (state_q == FBM_ST_ERASE && !i_flash_erase_done);
      if (i_watchdog_overflow && o_mode == FBM_MODE_BOOT) begin
        o_run_program <= 1'b0;
      end else if (state_q == FBM_ST_RUN) begin
        o_run_program <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Serial enables and transmit pin direction; the loader owns the enables
  // during boot, software owns them once the program runs
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rx_en_q <= 1'b0;
      tx_en_q <= 1'b0;
      o_txd_oe <= 1'b0;
    end else if (state_q == FBM_ST_SEND_ACK) begin
      rx_en_q <= 1'b1;
      tx_en_q <= 1'b1;
      o_txd_oe <= 1'b1;
    end else if (state_q == FBM_ST_RUN) begin
      rx_en_q <= 1'b0;
      tx_en_q <= 1'b0;
    end else if (i_watchdog_overflow && o_mode == FBM_MODE_BOOT) begin
      rx_en_q <= 1'b0;
      tx_en_q <= 1'b0;
    end else if (i_wr && i_addr == `FBM_OFF_SERIAL_CONTROL) begin
      rx_en_q <= i_wdata[`FBM_BIT_SERIAL_RECEIVE_ENABLE];
      tx_en_q <= i_wdata[`FBM_BIT_SERIAL_TRANSMIT_ENABLE];
      o_txd_oe <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Boot serial channel
  // 8N1 framing
  fbm_serial #(
    .DIV_W(DIV_W)
  ) u_serial (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_div(div_q),
    .i_rx_en(rx_en_q),
    .i_tx_en(tx_en_q || tx_start),
    .i_rxd(i_rxd),
    .o_rx_valid(rx_valid),
    .o_rx_data(rx_data),
    .o_rx_err(rx_err),
    .i_tx_start(tx_start),
    .i_tx_data(`FBM_BYTE_RATE_DONE),
    .o_tx_busy(tx_busy),
    .o_txd(o_txd)
  );

  // Framing errors are not reported; the host sees no reply and resets
  logic unused_rx_err;
  assign unused_rx_err = rx_err;

  // Control register contents toward the flash array
  assign o_flash_control_one = {1'b0, fc1_q};
  assign o_erase_block_select = ebr_q;

endmodule : fbm_flash_boot_ctrl

// ===== sim/fbm_flash_boot_ctrl_properties.sv
`timescale 1ns/1ps
module fbm_props (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic [7:0] i_addr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic i_test,
  input wire logic i_nmi,
  input wire logic i_port8_pin5,
  input wire fbm_pkg::fbm_mode_t o_mode,
  input wire logic i_subactive,
  input wire logic i_watchdog_overflow,
  input wire logic o_flash_powerdown,
  input wire logic o_flash_erase_all,
  input wire logic o_txd,
  input wire logic o_txd_oe,
  input wire logic o_ram_we,
  input wire logic [15:0] o_ram_addr,
  input wire logic o_run_program
);
  import fbm_pkg::*;
  // One domain, so clock and reset are given once
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (!i_arst_n);
  pd_cause_a: assert property (o_flash_powerdown |-> $past(i_subactive)) else $error("powerdown");
  rsvd_zero_a: assert property ($past(i_rd) && $past(i_addr) inside {8'h03, 8'h04} |-> o_rdata[6:0] == 7'h00)
    else $error("reserved bits");
  rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 8'h00) else $error("rdata idle");
  boot_strap_a: assert property (o_mode == FBM_MODE_BOOT |-> !i_test && !i_nmi && i_port8_pin5)
    else $error("boot straps");
  ram_window_a: assert property (o_ram_we |-> o_ram_addr >= 16'hf780 && o_ram_addr <= 16'hfeef)
    else $error("ram window");
  // The last program byte is written in the same cycle as the erase request rises
  erase_order_a: assert property ($rose(o_flash_erase_all) |-> o_ram_we)
    else $error("erase early");
  run_txd_a: assert property (o_run_program |-> o_txd && o_txd_oe) else $error("txd at run");
  wdt_exit_a: assert property (o_mode == FBM_MODE_BOOT && i_watchdog_overflow |-> ##[1:2]
    (o_mode == FBM_MODE_USER && !o_run_program)) else $error("watchdog exit");
  txd_idle_a: assert property (!o_txd_oe |-> o_txd) else $error("txd idle");
endmodule : fbm_props
bind fbm_flash_boot_ctrl fbm_props u_props (.i_clk, .i_arst_n, .i_addr, .i_rd, .o_rdata, .i_test, .i_nmi,
  .i_port8_pin5, .o_mode, .i_subactive, .i_watchdog_overflow, .o_flash_powerdown, .o_flash_erase_all,
  .o_txd, .o_txd_oe, .o_ram_we, .o_ram_addr, .o_run_program);

// ===== sim/fbm_host_model.sv
`timescale 1ns/1ps
module fbm_host_model #(
  // Rate scaled to the fast clock
  parameter int BIT = 20
) (
  input wire logic i_clk,
  input wire logic i_txd,
  output logic o_rxd
);
  logic [7:0] ack_q;
  // Line idles high at reset end
  initial o_rxd = 1'b1;
  // One start, eight data LSB first, one stop
  task send_byte(input logic [7:0] b);
    for (int k = 0; k < 10; k++) begin
      o_rxd <= (k == 0) ? 1'b0 : (k == 9) ? 1'b1 : b[k-1];
      repeat (BIT) @(posedge i_clk);
    end
  endtask : send_byte
  task rate_sync();
    fork
      forever send_byte(8'h00);
      begin
        @(negedge i_txd);
        repeat (BIT / 2) @(posedge i_clk);
        for (int k = 0; k < 8; k++) begin
          repeat (BIT) @(posedge i_clk);
          ack_q[k] = i_txd;
        end
      end
    join_any
    disable fork;
    // The cut zero byte finishes with ones and is read as junk or dropped, so idle long before replying
    o_rxd <= 1'b1;
    repeat (20 * BIT) @(posedge i_clk);
  endtask : rate_sync
endmodule : fbm_host_model

// ===== sim/testbench.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin num_errors++; $display("ERROR %s exp %h got %h", nm, e, g); end end
module testbench;
  import fbm_pkg::*;
  logic i_clk, i_arst_n, i_wr, i_rd, i_test, i_nmi, i_port8_pin5, i_portb_pin0, i_portb_pin1, i_portb_pin2;
  logic i_subactive, i_watchdog_overflow, i_flash_error, i_flash_erase_done, i_rxd, rd_seen;
  logic o_flash_powerdown, o_flash_erase_all, o_txd, o_txd_oe, o_ram_we, o_run_program;
  logic [7:0] i_addr, i_wdata, o_rdata, o_flash_control_one, o_ram_wdata, b, m;
  logic [15:0] o_ram_addr;
  logic [4:0] o_erase_block_select;
  logic [15:0] rd_q[$];
  logic [23:0] ram_q[$];
  fbm_mode_t o_mode;
  int num_errors = 0;
  int cmp_count = 0;
  int seed = 32'h50baa492;
  fbm_flash_boot_ctrl DUT (.i_clk, .i_arst_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_test, .i_nmi,
    .i_port8_pin5, .i_portb_pin0, .i_portb_pin1, .i_portb_pin2, .o_mode, .i_subactive, .i_watchdog_overflow,
    .i_flash_error, .i_flash_erase_done, .o_flash_powerdown, .o_flash_erase_all, .o_flash_control_one,
    .o_erase_block_select, .i_rxd, .o_txd, .o_txd_oe, .o_ram_we, .o_ram_addr, .o_ram_wdata, .o_run_program);
  fbm_host_model #(.BIT(20)) host (.i_clk, .i_txd(o_txd), .o_rxd(i_rxd));
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end
  task wr(input logic [7:0] a, input logic [7:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
    @(posedge i_clk);
  endtask : wr
  // Note holds a compare mask and the expected byte
  task rd(input logic [7:0] a, input logic [7:0] mk, input logic [7:0] e);
    rd_q.push_back({mk, e});
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(posedge i_clk);
  endtask : rd
  // Straps settle long before release and stay put
  task rst(input logic [5:0] s, input int n);
    {i_test, i_nmi, i_port8_pin5, i_portb_pin0, i_portb_pin1, i_portb_pin2} <= s;
    i_arst_n <= 1'b0;
    repeat (n) @(posedge i_clk);
    i_arst_n <= 1'b1;
    repeat (2) @(posedge i_clk);
  endtask : rst
  task wrap_up();
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : wrap_up
  // Outputs are taken at each edge, before that edge's updates land
  always @(posedge i_clk) begin
    if (rd_seen) begin
      m = rd_q[0][15:8] & o_rdata;
      `CHK("rdata", rd_q[0][7:0], m)
      void'(rd_q.pop_front());
    end
    if (o_ram_we) begin
      `CHK("ram", ram_q[0], {o_ram_addr, o_ram_wdata})
      void'(ram_q.pop_front());
    end
    rd_seen = i_rd;
  end
  initial begin
    repeat (20000) @(posedge i_clk);
    num_errors++;
    wrap_up();
  end
  initial begin
    {i_wr, i_rd, i_subactive, i_watchdog_overflow, i_flash_error, i_flash_erase_done, rd_seen} = '0;
    i_addr = 8'h00;
    i_wdata = 8'h00;
    rst(6'b010000, 3);
    `CHK("mode", FBM_MODE_USER, o_mode)
    rd(8'h04, 8'hff, 8'h00);
    wr(8'h03, 8'h80);
    i_flash_error <= 1'b1;
    rd(8'h01, 8'hff, 8'h00);
    wr(8'h04, 8'hff);
    rd(8'h04, 8'hff, 8'h80);
    rd(8'h03, 8'hff, 8'h00);
    rd(8'h01, 8'hff, 8'h80);
    wr(8'h00, 8'h40);
    wr(8'h02, 8'h04);
    `CHK("ebr", 13'h0804, {o_flash_control_one, o_erase_block_select})
    wr(8'h02, 8'h06);
    `CHK("ebr", 5'h00, o_erase_block_select)
    wr(8'h03, 8'hff);
    i_subactive <= 1'b1;
    rd(8'h03, 8'hff, 8'h80);
    rd(8'h3c, 8'hff, 8'h00);
    `CHK("powerdown", 1'b0, o_flash_powerdown)
    wr(8'h03, 8'h00);
    @(negedge i_clk);
    `CHK("powerdown", 1'b1, o_flash_powerdown)
    @(posedge i_clk);
    rst(6'b100000, 20);
    `CHK("mode", FBM_MODE_PROG, o_mode)
    rst(6'b100100, 20);
    `CHK("mode", FBM_MODE_NONE, o_mode)
    rst(6'b001000, 20);
    `CHK("mode", FBM_MODE_BOOT, o_mode)
    host.rate_sync();
    `CHK("ack", 8'h00, host.ack_q)
    if (host.ack_q !== 8'h00) begin
      rst(6'b001000, 20);
      host.rate_sync();
    end
    // Reply, then a two-byte length and the program
    host.send_byte(8'h55);
    host.send_byte(8'h00);
    host.send_byte(8'h06);
    for (int k = 0; k < 6; k++) begin
      b = 8'($random(seed));
      ram_q.push_back({16'hf780 + k[15:0], b});
      host.send_byte(b);
    end
    for (int k = 0; k < 2000 && !o_flash_erase_all; k++) @(posedge i_clk);
    `CHK("erase", 1'b1, o_flash_erase_all)
    i_flash_erase_done <= 1'b1;
    @(posedge i_clk);
    i_flash_erase_done <= 1'b0;
    for (int k = 0; k < 50 && !o_run_program; k++) @(posedge i_clk);
    `CHK("run", 1'b1, o_run_program)
    rd(8'h08, 8'h03, 8'h00);
    rd(8'h06, 8'hfc, 8'h14);
    rd(8'h07, 8'hff, 8'h00);
    i_watchdog_overflow <= 1'b1;
    repeat (3) @(posedge i_clk);
    `CHK("wdt mode", FBM_MODE_USER, o_mode)
    wrap_up();
  end
endmodule : testbench
